// File: shared/eoi_consts.vh
// register indices, field positions, reset values and frame geometry of the overhead inserter
`ifndef EOI_CONSTS_VH
`define EOI_CONSTS_VH

// register indices; byte address is four times the index
`define EOI_IDX_MODE 7'h62
`define EOI_IDX_SPARE_CTRL 7'h64
`define EOI_IDX_SPARE4 7'h65
`define EOI_IDX_SPARE5 7'h66
`define EOI_IDX_SPARE6 7'h67
`define EOI_IDX_SPARE7 7'h68
`define EOI_IDX_SPARE8 7'h69
`define EOI_IDX_EXTRA 7'h6A
`define EOI_IDX_MAINT_A 7'h6B
`define EOI_IDX_MAINT_B 7'h6C
`define EOI_IDX_IRQ_EN 7'h6D
`define EOI_IDX_IRQ_FLAG 7'h6E

// reset values
`define EOI_RST_MODE 8'h06
`define EOI_RST_SPARE_CTRL 8'h00
`define EOI_RST_CODEWORD 8'h0F
`define EOI_RST_EXTRA 8'h0B
`define EOI_RST_MAINT 8'h00
`define EOI_RST_IRQ 8'h00

// frame mode register fields
`define EOI_MODE_EXTRA_REPLACE_DISABLE 6
`define EOI_MODE_SIGEN 2
`define EOI_MODE_GENCRC 1
`define EOI_MODE_FDIS 0

// extra bits register fields
`define EOI_X0 3
`define EOI_X1 1
`define EOI_X2 0

// maintenance a fields
`define EOI_MA_TS16_ZERO 5
`define EOI_MA_TS16_ONES 4
`define EOI_MA_MF_ALARM 3
`define EOI_MA_CRIT_SEL 2
`define EOI_MA_AUTO_RAI 1
`define EOI_MA_MANUAL_RAI 0

// maintenance b fields
`define EOI_MB_SLIP 4
`define EOI_MB_TX_ZERO 3
`define EOI_MB_TX_ONES 2

// interrupt enable and flag fields
`define EOI_IRQ_SUBMF 4
`define EOI_IRQ_ALIGN 3
`define EOI_IRQ_SIGMF 2
`define EOI_IRQ_CRCMF 1
`define EOI_IRQ_BASIC 0

// frame geometry
`define EOI_BITS_PER_SLOT 8
`define EOI_SLOTS_PER_FRAME 32
`define EOI_FRAMES_PER_MF 16
`define EOI_FRAMES_PER_SUBMF 8
`define EOI_SLOT_SIG 5'h10
`define EOI_FAS_PATTERN 7'h1B

`endif

// File: src/eoi_overhead_inserter.v
// E1 transmit overhead and maintenance inserter with its register bank on an Avalon-MM slave
//
// How it works
// (R01) spare enables b4..b0 gate code-word insertion
// (R02) cleared enable leaves spare bits untouched
// (R03) basic frame only: code bit 1 inserted
// (R04) CRC multiframe: four code bits per sub-multiframe
// (R05) extra bits go to slot16 bits 5,7,8
// (R06) slot16 zero fill forces slot16 zeros
// (R07) slot16 ones fill forces slot16 ones unless slot16 zero fill is set
// (R08) multiframe alarm value sent in bit 6
// (R09) criteria 0: four remote alarm causes
// (R10) criteria 1: sync loss or manual only
// (R11) automatic alarm sets A bit when enabled
// (R12) manual alarm forces A bit to one
// (R13) each slip toggle edge repeats one bit
// (R14) transmit zero fill forces whole stream zero
// (R15) transmit ones fill forces whole stream one unless transmit zero fill is set
// (R16) sub-multiframe enable gates its flag onto irq
// (R17) other four enables gate their flags likewise
// (R18) start flags set on first bit, W1C
// (R19) extra disable blocks extra-bit replacement
// (R20) extra bits and alarm value sampled at multiframe boundary, code words per sub-multiframe (per frame without CRC)
`timescale 1ns/10ps
`include "eoi_consts.vh"

module eoi_overhead_inserter (
	input wire core_clk,
	input wire nrst,
	input wire [8:0] avs_address,
	input wire [3:0] avs_byteenable,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	output reg [31:0] avs_readdata,
	output wire avs_waitrequest,
	input wire tx_bit_en,
	input wire tx_data_in,
	output reg tx_data_out,
	output reg tx_data_valid,
	input wire rx_basic_sync_loss,
	input wire rx_crc_interwork,
	input wire rx_offline_sync_loss,
	output wire irq
);

	////////////////////////////////////////////////////////////////////////////////
	// registers

	localparam [7:0] RST_SPARE_CTRL = `EOI_RST_SPARE_CTRL;
	localparam [7:0] RST_CODEWORD = `EOI_RST_CODEWORD;
	localparam [7:0] RST_EXTRA = `EOI_RST_EXTRA;
	localparam [7:0] RST_MAINT = `EOI_RST_MAINT;
	localparam [7:0] RST_IRQ = `EOI_RST_IRQ;

	reg [7:0] mode_reg;
	reg [4:0] spare_ctrl_reg;
	reg [3:0] spare_grp4_code;
	reg [3:0] spare_grp5_code;
	reg [3:0] spare_grp6_code;
	reg [3:0] spare_grp7_code;
	reg [3:0] spare_grp8_code;
	reg [3:0] extra_reg;
	reg [5:0] maint_a_reg;
	reg [4:0] maint_b_reg;
	reg [4:0] irq_en_reg;
	reg [4:0] irq_flag_reg;
	reg [4:0] irq_flag_next;
	reg ack_reg;

	wire [6:0] reg_idx;
	wire wr_hit;
	wire [7:0] wdata;
	reg [7:0] rdata_next;

	assign reg_idx = avs_address[8:2];
	assign wdata = avs_writedata[7:0];
	// one wait cycle: the request is taken at the edge after the ack flop rises
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
	assign wr_hit = avs_write & ack_reg & avs_byteenable[0];

	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= (avs_read | avs_write) & ~ack_reg;
		end
	end

	wire extra_replace_disable;
	wire gen_sig_mf;
	wire gen_crc_mf;
	wire gen_basic;
	assign extra_replace_disable = mode_reg[`EOI_MODE_EXTRA_REPLACE_DISABLE];
	assign gen_basic = ~mode_reg[`EOI_MODE_FDIS];
	assign gen_sig_mf = gen_basic & mode_reg[`EOI_MODE_SIGEN];
	assign gen_crc_mf = gen_basic & mode_reg[`EOI_MODE_GENCRC];

	wire slot16_zero_fill;
	wire slot16_ones_fill;
	wire multiframe_alarm_value;
	wire alarm_criteria_select;
	wire auto_remote_alarm_en;
	wire manual_remote_alarm;
	wire alignment_slip_toggle;
	wire tx_zero_fill;
	wire tx_ones_fill;
	assign slot16_zero_fill = maint_a_reg[`EOI_MA_TS16_ZERO];
	assign slot16_ones_fill = maint_a_reg[`EOI_MA_TS16_ONES];
	assign multiframe_alarm_value = maint_a_reg[`EOI_MA_MF_ALARM];
	assign alarm_criteria_select = maint_a_reg[`EOI_MA_CRIT_SEL];
	assign auto_remote_alarm_en = maint_a_reg[`EOI_MA_AUTO_RAI];
	assign manual_remote_alarm = maint_a_reg[`EOI_MA_MANUAL_RAI];
	assign alignment_slip_toggle = maint_b_reg[`EOI_MB_SLIP];
	assign tx_zero_fill = maint_b_reg[`EOI_MB_TX_ZERO];
	assign tx_ones_fill = maint_b_reg[`EOI_MB_TX_ONES];

	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			mode_reg <= `EOI_RST_MODE;
			spare_ctrl_reg <= RST_SPARE_CTRL[4:0];
			spare_grp4_code <= RST_CODEWORD[3:0];
			spare_grp5_code <= RST_CODEWORD[3:0];
			spare_grp6_code <= RST_CODEWORD[3:0];
			spare_grp7_code <= RST_CODEWORD[3:0];
			spare_grp8_code <= RST_CODEWORD[3:0];
			extra_reg <= RST_EXTRA[3:0];
			maint_a_reg <= RST_MAINT[5:0];
			maint_b_reg <= RST_MAINT[4:0];
			irq_en_reg <= RST_IRQ[4:0];
		end else if (wr_hit) begin
			case (reg_idx)
				`EOI_IDX_MODE: mode_reg <= wdata & 8'h7F;
				`EOI_IDX_SPARE_CTRL: spare_ctrl_reg <= wdata[4:0];
				`EOI_IDX_SPARE4: spare_grp4_code <= wdata[3:0];
				`EOI_IDX_SPARE5: spare_grp5_code <= wdata[3:0];
				`EOI_IDX_SPARE6: spare_grp6_code <= wdata[3:0];
				`EOI_IDX_SPARE7: spare_grp7_code <= wdata[3:0];
				`EOI_IDX_SPARE8: spare_grp8_code <= wdata[3:0];
				`EOI_IDX_EXTRA: extra_reg <= wdata[3:0] & 4'hB;
				`EOI_IDX_MAINT_A: maint_a_reg <= wdata[5:0];
				`EOI_IDX_MAINT_B: maint_b_reg <= wdata[4:0] & 5'h1C;
				`EOI_IDX_IRQ_EN: irq_en_reg <= wdata[4:0];
				default: ;
			endcase
		end
	end

	always @* begin
		case (reg_idx)
			`EOI_IDX_MODE: rdata_next = mode_reg;
			`EOI_IDX_SPARE_CTRL: rdata_next = {3'h0, spare_ctrl_reg};
			`EOI_IDX_SPARE4: rdata_next = {4'h0, spare_grp4_code};
			`EOI_IDX_SPARE5: rdata_next = {4'h0, spare_grp5_code};
			`EOI_IDX_SPARE6: rdata_next = {4'h0, spare_grp6_code};
			`EOI_IDX_SPARE7: rdata_next = {4'h0, spare_grp7_code};
			`EOI_IDX_SPARE8: rdata_next = {4'h0, spare_grp8_code};
			`EOI_IDX_EXTRA: rdata_next = {4'h0, extra_reg};
			`EOI_IDX_MAINT_A: rdata_next = {2'h0, maint_a_reg};
			`EOI_IDX_MAINT_B: rdata_next = {3'h0, maint_b_reg};
			`EOI_IDX_IRQ_EN: rdata_next = {3'h0, irq_en_reg};
			`EOI_IDX_IRQ_FLAG: rdata_next = {3'h0, irq_flag_reg};
			default: rdata_next = 8'h00;
		endcase
	end

	// read data is loaded in the wait cycle, stands at the accepting edge
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			avs_readdata <= 32'h00000000;
		end else if (avs_read & ~ack_reg) begin
			avs_readdata <= {24'h000000, rdata_next};
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// frame position

	reg [2:0] bit_pos_reg;
	reg [4:0] slot_reg;
	reg [3:0] frame_reg;
	reg slip_prev_reg;
	reg slip_pend_reg;
	wire slip_edge;
	wire hold_pos;

	assign slip_edge = alignment_slip_toggle ^ slip_prev_reg;
	// repetition chosen: the position stands still for one bit
	assign hold_pos = slip_pend_reg & tx_bit_en;

	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			slip_prev_reg <= 1'b0;
			slip_pend_reg <= 1'b0;
		end else begin
			slip_prev_reg <= alignment_slip_toggle;
			if (slip_edge) begin
				slip_pend_reg <= 1'b1; // see (R13)
			end else if (hold_pos) begin
				slip_pend_reg <= 1'b0;
			end
		end
	end

	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			bit_pos_reg <= 3'h0;
			slot_reg <= 5'h00;
			frame_reg <= 4'h0;
		end else if (tx_bit_en & ~hold_pos) begin // see (R13)
			bit_pos_reg <= bit_pos_reg + 3'h1;
			if (bit_pos_reg == 3'h7) begin
				slot_reg <= slot_reg + 5'h01;
				if (slot_reg == 5'h1F) begin
					frame_reg <= frame_reg + 4'h1;
				end
			end
		end
	end

	wire first_bit;
	wire frame_start;
	wire submf_start;
	wire mf_start;
	assign first_bit = (bit_pos_reg == 3'h0) & (slot_reg == 5'h00);
	assign frame_start = tx_bit_en & first_bit;
	assign submf_start = frame_start & (frame_reg[2:0] == 3'h0);
	assign mf_start = frame_start & (frame_reg == 4'h0);

	////////////////////////////////////////////////////////////////////////////////
	// overhead shadows, taken only at boundaries

	reg [19:0] code_sh_reg;
	reg [4:0] spare_en_sh_reg;
	reg [3:0] extra_sh_reg;
	reg extra_replace_disable_sh_reg;
	reg y_sh_reg;

	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			code_sh_reg <= {5{RST_CODEWORD[3:0]}};
			spare_en_sh_reg <= 5'h00;
			extra_sh_reg <= RST_EXTRA[3:0];
			extra_replace_disable_sh_reg <= 1'b0;
			y_sh_reg <= 1'b0;
		end else begin
			// code words swap per sub-multiframe, or per frame without CRC
			if (gen_crc_mf ? submf_start : frame_start) begin // see (R20)
				code_sh_reg <= {spare_grp4_code, spare_grp5_code, spare_grp6_code,
					spare_grp7_code, spare_grp8_code};
				spare_en_sh_reg <= spare_ctrl_reg;
			end
			if (mf_start) begin // see (R20)
				extra_sh_reg <= extra_reg;
				extra_replace_disable_sh_reg <= extra_replace_disable;
				y_sh_reg <= multiframe_alarm_value;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// remote alarm

	wire alarm_cause;
	wire a_bit_force;
	assign alarm_cause = alarm_criteria_select ?
		(rx_basic_sync_loss | manual_remote_alarm) : // see (R10)
		(rx_basic_sync_loss | rx_crc_interwork | rx_offline_sync_loss | manual_remote_alarm); // see (R09)
	assign a_bit_force = gen_basic & (manual_remote_alarm | (auto_remote_alarm_en & alarm_cause)); // see (R11) (R12)

	////////////////////////////////////////////////////////////////////////////////
	// bit insertion

	wire in_nfas;
	wire in_slot16_f0;
	wire [1:0] code_sel;
	reg out_bit;
	reg [2:0] grp;

	assign in_nfas = gen_basic & (slot_reg == 5'h00) & frame_reg[0];
	assign in_slot16_f0 = gen_sig_mf & (slot_reg == `EOI_SLOT_SIG) & (frame_reg == 4'h0);
	// code bit 1 is the msb; odd frames 1,3,5,7 of a sub-multiframe carry bits 1..4
	assign code_sel = gen_crc_mf ? frame_reg[2:1] : 2'h0; // see (R03) (R04)

	always @* begin
		out_bit = tx_data_in;
		grp = 3'h0;
		if (in_nfas && bit_pos_reg >= 3'h3) begin
			grp = bit_pos_reg - 3'h3;
			if (spare_en_sh_reg[3'h4 - grp]) begin // see (R01) (R02)
				out_bit = code_sh_reg[5'd19 - {grp, 2'b00} - {3'h0, code_sel}];
			end
		end
		if (in_nfas && bit_pos_reg == 3'h2 && a_bit_force) begin
			out_bit = 1'b1;
		end
		if (in_slot16_f0) begin
			if (bit_pos_reg == 3'h5) begin
				out_bit = y_sh_reg; // see (R08)
			end
			if (!extra_replace_disable_sh_reg) begin // see (R19)
				case (bit_pos_reg)
					3'h4: out_bit = extra_sh_reg[`EOI_X0]; // see (R05)
					3'h6: out_bit = extra_sh_reg[`EOI_X1]; // see (R05)
					3'h7: out_bit = extra_sh_reg[`EOI_X2]; // see (R05)
					default: ;
				endcase
			end
		end
		if (slot_reg == `EOI_SLOT_SIG) begin
			if (slot16_zero_fill) begin
				out_bit = 1'b0; // see (R06)
			end else if (slot16_ones_fill) begin
				out_bit = 1'b1; // see (R07)
			end
		end
		if (tx_zero_fill) begin
			out_bit = 1'b0; // see (R14)
		end else if (tx_ones_fill) begin
			out_bit = 1'b1; // see (R15)
		end
	end

	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			tx_data_out <= 1'b0;
			tx_data_valid <= 1'b0;
		end else begin
			tx_data_valid <= tx_bit_en;
			if (tx_bit_en) begin
				tx_data_out <= out_bit;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// start flags and interrupt

	wire [4:0] flag_set;
	wire [4:0] flag_clr;
	assign flag_set[`EOI_IRQ_SUBMF] = gen_crc_mf & submf_start;
	assign flag_set[`EOI_IRQ_ALIGN] = gen_basic & frame_start & ~frame_reg[0];
	assign flag_set[`EOI_IRQ_SIGMF] = gen_sig_mf & mf_start;
	assign flag_set[`EOI_IRQ_CRCMF] = gen_crc_mf & mf_start;
	assign flag_set[`EOI_IRQ_BASIC] = gen_basic & frame_start;
	assign flag_clr = (wr_hit && reg_idx == `EOI_IDX_IRQ_FLAG) ? wdata[4:0] : 5'h00;

	always @* begin
		irq_flag_next = (irq_flag_reg & ~flag_clr) | flag_set; // see (R18)
	end

	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			irq_flag_reg <= RST_IRQ[4:0];
		end else begin
			irq_flag_reg <= irq_flag_next;
		end
	end

	assign irq = |(irq_flag_reg & irq_en_reg); // see (R16) (R17)

endmodule // eoi_overhead_inserter

// File: testbench/eoi_checker_assertions.sv
// port checker for the overhead inserter
`timescale 1ns/10ps
`include "eoi_consts.vh"
module eoi_checker (
	input wire core_clk,
	input wire nrst,
	input wire [8:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [31:0] avs_readdata,
	input wire avs_waitrequest,
	input wire tx_bit_en,
	input wire tx_data_out,
	input wire tx_data_valid,
	input wire irq
);
	// shadows change at the accepting edge, same as the bank
	reg [7:0] mb_reg;
	reg [7:0] ie_reg;
	wire wr_ok = avs_write && !avs_waitrequest;
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			mb_reg <= 8'h00;
			ie_reg <= 8'h00;
		end else if (wr_ok) begin
			if (avs_address[8:2] == `EOI_IDX_MAINT_B)
				mb_reg <= avs_writedata[7:0];
			if (avs_address[8:2] == `EOI_IDX_IRQ_EN)
				ie_reg <= avs_writedata[7:0];
		end
	end
	////////////////////////////////////////
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!nrst);
	sequence s_pend;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	sequence s_acc;
		!avs_waitrequest;
	endsequence
	property p_one_wait;
		$rose(avs_read || avs_write) |-> s_pend ##1 s_acc;
	endproperty
	a_one_wait: assert property (p_one_wait) else $error("request not answered after one wait state");
	property p_rearm;
		(avs_read || avs_write) && !avs_waitrequest |=> !(avs_read || avs_write) || avs_waitrequest;
	endproperty
	a_rearm: assert property (p_rearm) else $error("new request accepted without wait state");
	property p_rd_hi;
		avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h000000;
	endproperty
	a_rd_hi: assert property (p_rd_hi) else $error("upper read lanes not zero");
	property p_unmapped;
		avs_read && !avs_waitrequest && (avs_address[8:2] < 7'h62 || avs_address[8:2] > 7'h6E)
			|-> avs_readdata == 32'h00000000;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_valid;
		tx_bit_en |=> tx_data_valid;
	endproperty
	a_valid: assert property (p_valid) else $error("bit taken without valid");
	property p_novalid;
		tx_data_valid |-> $past(tx_bit_en);
	endproperty
	a_novalid: assert property (p_novalid) else $error("valid without bit");
	property p_hold;
		!tx_bit_en |=> $stable(tx_data_out);
	endproperty
	a_hold: assert property (p_hold) else $error("output bit changed between bits");
	property p_zero;
		tx_bit_en && mb_reg[`EOI_MB_TX_ZERO] |=> !tx_data_out;
	endproperty
	a_zero: assert property (p_zero) else $error("zero fill not applied");
	property p_ones;
		tx_bit_en && mb_reg[`EOI_MB_TX_ONES] && !mb_reg[`EOI_MB_TX_ZERO] |=> tx_data_out;
	endproperty
	a_ones: assert property (p_ones) else $error("ones fill not applied");
	property p_irq_gate;
		ie_reg[4:0] == 5'h00 |-> !irq;
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("irq with all enables clear");
endmodule // eoi_checker
bind eoi_overhead_inserter eoi_checker u_checker (.core_clk(core_clk), .nrst(nrst), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .tx_bit_en(tx_bit_en), .tx_data_out(tx_data_out),
	.tx_data_valid(tx_data_valid), .irq(irq));

// File: testbench/eoi_line_partner.sv
// frame generator side: feeds bits at full or ragged rate
`timescale 1ns/10ps
module eoi_line_partner (
	input wire core_clk,
	input wire nrst,
	input wire slow,
	output reg tx_bit_en = 1'b0,
	output reg tx_data_in = 1'b0
);
	// data changes every cycle so nothing leans on a stale bit
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			tx_bit_en <= 1'b0;
			tx_data_in <= 1'b0;
		end else begin
			tx_bit_en <= slow ? ($urandom % 2 == 0) : 1'b1;
			tx_data_in <= 1'($urandom);
		end
	end
endmodule // eoi_line_partner

// File: testbench/eoi_overhead_inserter_test.sv
// self-checking bench for the overhead inserter
`timescale 1ns/10ps
module eoi_overhead_inserter_test;
	logic core_clk = 1'b0, nrst = 1'b0, slow = 1'b0, chk_on = 1'b0;
	logic avs_read = 1'b0, avs_write = 1'b0, rx_bsl = 1'b0, rx_ci = 1'b0, rx_os = 1'b0;
	logic [8:0] avs_address = 9'h000;
	logic [31:0] avs_writedata = 32'h00000000, avs_readdata;
	logic avs_waitrequest, tx_bit_en, tx_data_in, tx_data_out, tx_data_valid, irq;
	logic [7:0] mode = 8'h06, sctl = 8'h00, ext = 8'h0B, ma = 8'h00, mb = 8'h00;
	logic [3:0] cw [5];
	logic [11:0] pos = 12'h000;
	logic [15:0] rq [$];
	logic [1:0] sq [$];
	logic [15:0] e1;
	logic [1:0] e2;
	int n_errors = 0, check_count = 0, mf_cnt = 0, nbits = 0, n0;
	eoi_overhead_inserter DUT (.core_clk(core_clk), .nrst(nrst), .avs_address(avs_address), .avs_byteenable(4'hF),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .tx_bit_en(tx_bit_en), .tx_data_in(tx_data_in),
		.tx_data_out(tx_data_out), .tx_data_valid(tx_data_valid), .rx_basic_sync_loss(rx_bsl),
		.rx_crc_interwork(rx_ci), .rx_offline_sync_loss(rx_os), .irq(irq));
	eoi_line_partner u_line (.core_clk(core_clk), .nrst(nrst), .slow(slow), .tx_bit_en(tx_bit_en),
		.tx_data_in(tx_data_in));
	initial forever #20 core_clk = ~core_clk;
	task print_verdict;
		if (n_errors == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task fail(input string m);
		$display("ERROR %0t %s", $time, m);
		n_errors++;
	endtask
	task bus(input logic wr, input logic [6:0] idx, input logic [7:0] wd);
		int n;
		n = 0;
		avs_address <= {idx, 2'b00};
		avs_writedata <= {24'h000000, wd};
		avs_write <= wr;
		avs_read <= !wr;
		do begin
			@(posedge core_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 40);
		if (n >= 40) begin
			fail("bus timeout");
			print_verdict;
		end
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge core_clk);
	endtask
	task rd(input logic [6:0] idx, input logic [7:0] ex, input logic [7:0] mk);
		rq.push_back({mk, ex});
		bus(1'b0, idx, 8'h00);
	endtask
	// reserved bits are written high, so readback proves they drop
	task wr(input logic [6:0] idx, input logic [7:0] v, input logic [7:0] mk);
		bus(1'b1, idx, v);
		rd(idx, v & mk, 8'hFF);
	endtask
	task wait_irq;
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 9000) begin
			@(posedge core_clk);
			n++;
		end
		if (n >= 9000) begin
			fail("irq never rose");
			print_verdict;
		end
	endtask
	task sync_mf;
		int c, n;
		c = mf_cnt;
		n = 0;
		while (mf_cnt == c && n < 20000) begin
			@(posedge core_clk);
			n++;
		end
		if (n >= 20000) begin
			fail("no multiframe start");
			print_verdict;
		end
	endtask
	// overhead is sampled at multiframe start at the latest, so skip one before checking
	task phase;
		sync_mf;
		chk_on = 1'b1;
		sync_mf;
		chk_on = 1'b0;
	endtask
	// returns {care, bit}; p = frame, slot, bit-1
	function logic [1:0] expv(input logic d, input logic [11:0] p);
		logic [2:0] b;
		logic al;
		b = p[2:0];
		al = ma[0] | (ma[1] & (rx_bsl | (!ma[2] & (rx_ci | rx_os))));
		expv = {1'b1, d};
		if (p[11:3] == 9'h010 && mode[2] && !mode[0]) begin
			if (b == 3'd5) expv[0] = ma[3];
			if (!mode[6] && b == 3'd4) expv[0] = ext[3];
			if (!mode[6] && b == 3'd6) expv[0] = ext[1];
			if (!mode[6] && b == 3'd7) expv[0] = ext[0];
		end
		// without an alarm the A bit passes through untouched
		if (!mode[0] && p[8] && p[7:3] == 5'h00 && b == 3'd2 && al) expv[0] = 1'b1;
		if (!mode[0] && p[8] && p[7:3] == 5'h00 && b > 3'd2 && sctl[3'd7 - b])
			expv[0] = mode[1] ? cw[b - 3'd3][2'd3 - p[10:9]] : cw[b - 3'd3][3];
		if (p[7:3] == 5'h10 && ma[4]) expv = 2'b11;
		if (p[7:3] == 5'h10 && ma[5]) expv = 2'b10;
		if (mb[2]) expv = 2'b11;
		if (mb[3]) expv = 2'b10;
	endfunction
	always @(posedge core_clk) if (nrst && tx_bit_en === 1'b1) begin
		sq.push_back(chk_on ? expv(tx_data_in, pos) : 2'b00);
		if (pos == 12'h000) mf_cnt++;
		pos++;
		nbits++;
	end
	always @(posedge core_clk) if (tx_data_valid === 1'b1) begin
		e2 = sq.pop_front();
		if (e2[1]) begin
			check_count++;
			if (tx_data_out !== e2[0]) fail("stream bit");
		end
	end
	always @(posedge core_clk) if (avs_read && avs_waitrequest === 1'b0) begin
		e1 = rq.pop_front();
		check_count++;
		if ((avs_readdata & {24'hFFFFFF, e1[15:8]}) !== {24'h000000, e1[7:0]}) fail("register read");
	end
	initial begin
		void'($urandom(16246));
		repeat (20) @(posedge core_clk);
		nrst <= 1'b1;
		@(posedge core_clk);
		for (int i = 7'h62; i <= 7'h70; i++)
			rd(i[6:0], (i >= 7'h65 && i <= 7'h69) ? 8'h0F : (i == 7'h62) ? 8'h06 : (i == 7'h6A) ? 8'h0B : 8'h00,
				(i == 7'h6E) ? 8'hE0 : 8'hFF);
		wr(7'h63, 8'hFF, 8'h00);
		sctl = $urandom & 8'h1F;
		ext = $urandom & 8'h0B;
		ma = 8'h01 | {4'h0, 1'($urandom), 3'b000};
		for (int g = 0; g < 5; g++) begin
			cw[g] = $urandom;
			wr(7'h65 + g[6:0], {4'hF, cw[g]}, 8'h0F);
		end
		wr(7'h64, sctl | 8'hE0, 8'h1F);
		wr(7'h6A, ext | 8'hF4, 8'h0B);
		wr(7'h6B, ma | 8'hC0, 8'h3F);
		phase;
		mode = 8'h44;
		ma = 8'h02;
		rx_ci <= 1'b1;
		wr(7'h62, mode | 8'h80, 8'h7F);
		wr(7'h6B, ma, 8'h3F);
		phase;
		mode = 8'h06;
		ma = 8'h16;
		rx_bsl <= 1'b1;
		wr(7'h62, mode, 8'h7F);
		wr(7'h6B, ma, 8'h3F);
		phase;
		// criteria 1 must ignore the interworking cause
		ma = 8'h36;
		rx_bsl <= 1'b0;
		wr(7'h6B, ma, 8'h3F);
		phase;
		mode = 8'h07;
		ma = 8'h01;
		wr(7'h62, mode, 8'h7F);
		wr(7'h6B, ma, 8'h3F);
		phase;
		slow <= 1'b1;
		for (int f = 0; f < 2; f++) begin
			mb = f ? 8'h0C : 8'h04;
			wr(7'h6C, mb | 8'hE3, 8'h1C);
			chk_on = 1'b1;
			repeat (300) @(posedge core_clk);
			chk_on = 1'b0;
		end
		mb = 8'h00;
		slow <= 1'b0;
		wr(7'h6C, mb, 8'h1C);
		mode = 8'h06;
		wr(7'h62, mode, 8'h7F);
		for (int k = 0; k < 5; k++) begin
			bus(1'b1, 7'h6E, 8'h1F);
			wr(7'h6D, 8'hE0 | (8'h01 << k), 8'h1F);
			wait_irq;
			rd(7'h6E, 8'h01 << k, 8'h01 << k);
		end
		// one repeated bit stretches the sub-multiframe to 2049 bits
		bus(1'b1, 7'h6E, 8'h1F);
		wait_irq;
		for (int k = 0; k < 2; k++) begin
			#1 n0 = nbits;
			@(posedge core_clk);
			bus(1'b1, 7'h6C, k ? 8'h00 : 8'h10);
			bus(1'b1, 7'h6E, 8'h1F);
			wait_irq;
			#1 check_count++;
			if (nbits - n0 != 2049) fail("slip count");
		end
		print_verdict;
	end
endmodule // eoi_overhead_inserter_test
